// ### dv/analog_front.sv
// analog pin and hold capacitor model feeding the comparator
// assumes dac_code is zero outside conversion
`default_nettype none
module analog_front (
   input wire logic ref_clk,
   input wire logic [11:0] ain_level,
   input wire logic sample_en,
   input wire logic [11:0] dac_code,
   output logic comp_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [11:0] held;
   logic junk = 1'b0;
   // outside conversion the answer is noise, never a stale level
   always @(posedge ref_clk) begin
      junk <= !junk;
      if (sample_en) held <= ain_level;
   end
   assign comp_in = |dac_code ? held >= dac_code : junk;
endmodule // analog_front
`default_nettype wire

// ### dv/sar_adc_sequencer_sva.sv
// port assertions for the sar adc sequencer
// assumes the bind at the foot reaches every instance
`include "sar_adc_defs.vh"
`default_nettype none
module sar_adc_checker #(
   parameter N_CHAN = 12
) (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic [`ADDR_W-1:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic waitrequest,
   input wire logic [`RESULT_BITS-1:0] dac_code,
   input wire logic sample_en,
   input wire logic vref_pos_ext,
   input wire logic [N_CHAN-1:0] pin_analog,
   input wire logic conv_complete_flag
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] cfg_wr;
   logic [1:0] clr_wr;
   wire logic taken = write && !waitrequest;
   // ****************
   // properties
   // ****************
   // two-deep history, outputs may lag the write by a cycle
   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         cfg_wr <= 2'h0;
         clr_wr <= 2'h0;
      end else begin
         cfg_wr <= {cfg_wr[0], taken && address == `OFS_CONTROL_ONE};
         clr_wr <= {clr_wr[0], taken && address == `OFS_STATUS};
      end
   end
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rstn);
   property p_reset_state;
      $rose(rstn) |-> !sample_en && !conv_complete_flag && &pin_analog;
   endproperty
   a_reset_state: assert property (p_reset_state) else $error("bad state after reset");
   property p_one_wait;
      (read || write) && waitrequest |=> !waitrequest;
   endproperty
   a_one_wait: assert property (p_one_wait) else $error("answer late");
   property p_wait_pulse;
      !waitrequest |=> waitrequest;
   endproperty
   a_wait_pulse: assert property (p_wait_pulse) else $error("answer too long");
   property p_hold_open;
      |dac_code |-> !sample_en;
   endproperty
   a_hold_open: assert property (p_hold_open) else $error("sampling while converting");
   property p_msb_first;
      $rose(|dac_code) |-> dac_code == 12'h800;
   endproperty
   a_msb_first: assert property (p_msb_first) else $error("first trial not msb");
   property p_guard;
      $rose(conv_complete_flag) |-> !sample_en [*3];
   endproperty
   a_guard: assert property (p_guard) else $error("sampling inside guard");
   property p_resume;
      $rose(conv_complete_flag) |-> ##[3:140] sample_en;
   endproperty
   a_resume: assert property (p_resume) else $error("sampling not resumed");
   property p_ref_sel;
      $changed(vref_pos_ext) |-> cfg_wr != 2'h0;
   endproperty
   a_ref_sel: assert property (p_ref_sel) else $error("reference moved unasked");
   property p_pin_cfg;
      $changed(pin_analog) |-> cfg_wr != 2'h0;
   endproperty
   a_pin_cfg: assert property (p_pin_cfg) else $error("pin mode moved unasked");
   property p_flag_clear;
      $fell(conv_complete_flag) |-> clr_wr != 2'h0;
   endproperty
   a_flag_clear: assert property (p_flag_clear) else $error("flag lost unasked");
endmodule // sar_adc_checker
bind sar_adc_sequencer sar_adc_checker #(.N_CHAN(N_CHAN)) u_sar_adc_checker (
   .ref_clk(ref_clk),
   .rstn(rstn),
   .address(address),
   .read(read),
   .write(write),
   .waitrequest(waitrequest),
   .dac_code(dac_code),
   .sample_en(sample_en),
   .vref_pos_ext(vref_pos_ext),
   .pin_analog(pin_analog),
   .conv_complete_flag(conv_complete_flag)
);
`default_nettype wire

// ### dv/tb_sar_adc_sequencer.sv
// self-checking bench for the sar adc sequencer
// assumes rtl on the include path and the analog front model
`include "sar_adc_defs.vh"
`default_nettype none
module tb_sar_adc_sequencer;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk, rstn, read, write, rc_osc_in, sleep_mode, comp_in, flag, flag_d;
   logic waitrequest, sample_en, vref_pos_ext, vref_neg_ext;
   logic [4:0] address;
   logic [31:0] writedata, readdata;
   logic [11:0] dac_code, pin_analog, level;
   logic [3:0] channel_sel;
   logic [7:0] rd;
   logic [31:0] rng = 32'h64fd;
   int error_cnt, tests_run, cyc, st_cyc, fl_cyc;
   int acq_tab[8] = '{0, 2, 4, 6, 8, 12, 16, 20};
   logic [2:0] cs_tab[8] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6, 3'h3, 3'h7};
   sar_adc_sequencer u_sar_adc_sequencer (.ref_clk(ref_clk), .rstn(rstn), .address(address),
      .read(read), .write(write), .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest), .comp_in(comp_in), .rc_osc_in(rc_osc_in),
      .sleep_mode(sleep_mode), .dac_code(dac_code), .sample_en(sample_en),
      .channel_sel(channel_sel), .vref_pos_ext(vref_pos_ext), .vref_neg_ext(vref_neg_ext),
      .pin_analog(pin_analog), .conv_complete_flag(flag));
   analog_front u_analog_front (.ref_clk(ref_clk), .ain_level(level), .sample_en(sample_en),
      .dac_code(dac_code), .comp_in(comp_in));
   // ****************
   // clocks, helpers
   // ****************
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   // rc source off the rising ref edges except one toggle in 100, which ties with one
   initial begin
      rc_osc_in = 1'b0;
      forever #41.3 rc_osc_in = ~rc_osc_in;
   end
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      flag_d <= flag;
      if (flag === 1'b1 && flag_d === 1'b0) fl_cyc <= cyc;
   end
   function automatic logic [31:0] rnd();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng;
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict();
      $display("errors %0d checks %0d", error_cnt, tests_run);
      if (error_cnt == 0 && tests_run > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge ref_clk);
      address <= a;
      writedata <= {24'h0, d};
      write <= wr;
      read <= !wr;
      do begin
         @(posedge ref_clk);
         n++;
      end while (waitrequest !== 1'b0 && n < 100);
      rd = readdata[7:0];
      write <= 1'b0;
      read <= 1'b0;
      if (n >= 100) error_cnt++;
   endtask
   task automatic convert(input logic [2:0] cs, input logic [2:0] acq, input logic fmt);
      logic [11:0] v;
      logic [3:0] ch;
      int conv_clock_period;
      int exp;
      int n;
      v = 12'(rnd());
      ch = 4'(rnd());
      conv_clock_period = 2 << (2 * cs[1:0] + cs[2]);
      exp = (acq_tab[acq] + 11) * conv_clock_period + 1;
      level <= v;
      sleep_mode <= cs[1:0] == 2'h3;
      bus(1'b1, `OFS_CONTROL_TWO, {fmt, 1'b0, acq, cs});
      bus(1'b1, `OFS_STATUS, 8'h01);
      bus(1'b1, `OFS_CONTROL_ZERO, {2'h0, ch, 2'h1});
      repeat (8) @(posedge ref_clk);
      bus(1'b1, `OFS_CONTROL_ZERO, {2'h0, ch, 2'h3});
      st_cyc = cyc;
      repeat (3) @(posedge ref_clk);
      if (acq == 3'h0) level <= ~v;
      n = 0;
      do begin
         bus(1'b0, `OFS_CONTROL_ZERO, 8'h00);
         n++;
      end while (rd[1] !== 1'b0 && n < 2000);
      if (cs[1:0] != 2'h3) check(fl_cyc - st_cyc >= exp && fl_cyc - st_cyc <= exp + conv_clock_period + 4, 1);
      bus(1'b0, `OFS_STATUS, 8'h00);
      check(rd, 8'h01);
      bus(1'b0, `OFS_RESULT_HIGH, 8'h00);
      check(rd, fmt ? {4'h0, v[11:8]} : v[11:4]);
      bus(1'b0, 5'h14, 8'h00);
      check(rd, fmt ? v[7:0] : {v[3:0], 4'h0});
      n = 0;
      while (sample_en !== 1'b1 && n < 300) begin
         @(posedge ref_clk);
         n++;
      end
      check(sample_en, 1'b1);
      check(channel_sel, ch);
   endtask
   // ****************
   // main sequence
   // ****************
   initial begin
      {rstn, read, write, address, writedata, sleep_mode, level, flag_d} = '0;
      {error_cnt, tests_run, cyc, fl_cyc} = '0;
      repeat (16) @(posedge ref_clk);
      rstn <= 1'b1;
      check(pin_analog, 12'hfff);
      bus(1'b1, `OFS_CONTROL_ZERO, 8'h02);
      bus(1'b0, `OFS_CONTROL_ZERO, 8'h00);
      check(rd, 8'h00);
      check(sample_en, 1'b0);
      bus(1'b0, 5'h18, 8'h00);
      check(rd, 8'h00);
      for (int p = 0; p < 16; p++) begin
         bus(1'b1, `OFS_CONTROL_ONE, {2'h0, p[1:0], p[3:0]});
         repeat (2) @(posedge ref_clk);
         check({vref_neg_ext, vref_pos_ext}, p[1:0]);
         check(pin_analog, p < 4 ? 12'hfff : 12'hfff >> (p - 3));
      end
      bus(1'b1, `OFS_CONTROL_ONE, 8'h00);
      bus(1'b1, `OFS_CONTROL_ZERO, 8'h01);
      for (int i = 0; i < 16; i++) convert(cs_tab[i % 8], i < 8 ? 3'(i) : 3'(rnd()), rnd() & 1);
      // slowest clock, longest acquisition; asleep the divided clock stalls, then abort
      sleep_mode <= 1'b1;
      bus(1'b1, `OFS_RESULT_HIGH, 8'ha5);
      bus(1'b1, `OFS_CONTROL_TWO, 8'h3e);
      bus(1'b1, `OFS_STATUS, 8'h01);
      bus(1'b1, `OFS_CONTROL_ZERO, 8'h03);
      repeat (1400) @(posedge ref_clk);
      check(sample_en, 1'b1);
      sleep_mode <= 1'b0;
      repeat (1000) @(posedge ref_clk);
      bus(1'b0, `OFS_CONTROL_ZERO, 8'h00);
      check(rd, 8'h03);
      repeat (600) @(posedge ref_clk);
      bus(1'b1, `OFS_CONTROL_ZERO, 8'h01);
      bus(1'b0, `OFS_CONTROL_ZERO, 8'h00);
      check(rd, 8'h01);
      bus(1'b0, `OFS_STATUS, 8'h00);
      check(rd, 8'h00);
      bus(1'b0, `OFS_RESULT_HIGH, 8'h00);
      check(rd, 8'ha5);
      bus(1'b1, `OFS_CONTROL_ZERO, 8'h03);
      repeat (1600) @(posedge ref_clk);
      rstn <= 1'b0;
      repeat (2) @(posedge ref_clk);
      rstn <= 1'b1;
      bus(1'b0, `OFS_CONTROL_ZERO, 8'h00);
      check(rd, 8'h00);
      bus(1'b0, `OFS_RESULT_HIGH, 8'h00);
      check(rd, 8'ha5);
      give_verdict();
   end
   initial begin
      #800000;
      error_cnt++;
      give_verdict();
   end
endmodule // tb_sar_adc_sequencer
`default_nettype wire

// ### rtl/sar_adc_defs.vh
// register offsets, field positions, reset values and timing counts
// for the sar adc sequencer; assumes a 100 MHz ref_clk
`ifndef SAR_ADC_DEFS_VH
`define SAR_ADC_DEFS_VH

// ****************************************
// register byte offsets
// ****************************************
`define OFS_CONTROL_ZERO 4'h0
`define OFS_CONTROL_ONE 4'h4
`define OFS_CONTROL_TWO 4'h8
`define OFS_RESULT_HIGH 4'hc
`define OFS_RESULT_LOW 4'h0
`define OFS_STATUS 5'h10
`define OFS_RESULT_LOW_FULL 5'h10
`define ADDR_W 5

// ****************************************
// field positions
// ****************************************
`define BIT_ENABLE 0
`define BIT_START 1
`define CHAN_LSB 2
`define PCFG_LSB 0
`define VREF_POS_BIT 4
`define VREF_NEG_BIT 5
`define CLKSEL_LSB 0
`define ACQ_LSB 3
`define FORMAT_BIT 7
`define BIT_FLAG 0

// ****************************************
// reset values
// ****************************************
`define RST_CONTROL 8'h00

// ****************************************
// timing
// ****************************************
`define REF_PERIOD_NS 10
`define INSTR_CYCLE_NS 40
`define INSTR_CYCLE_CYC ((`INSTR_CYCLE_NS + `REF_PERIOD_NS - 1) / `REF_PERIOD_NS)
`define CONV_PERIODS 11
`define GUARD_PERIODS 2
`define RESULT_BITS 12

`endif

// ### rtl/sar_adc_sequencer.v
// sequencer for a 12-bit successive-approximation converter with an
// avalon-mm register slave; assumes a comparator macro clocked by ref_clk
// and a free internal rc oscillator arriving on rc_osc_in
//
// Summary of operation
// R1: rc clock starts one instruction cycle late
// R2: software picks supply rails or reference pins
// R3: sleep conversion only on rc clock
// R4: result built by successive approximation from hold
// R5: each pin selectable analog or digital
// R6: completion loads result, clears start, sets flag
// R7: reset clears registers and aborts conversion
// R8: result pair untouched by any reset
// R9: software configures, starts, waits, then reads result
// R10: two clock periods before next acquisition
// R11: channel sampled for acquisition time first
// R12: hold capacitor disconnected during conversion
// R13: zero acquisition field converts at once
// R14: nonzero field samples programmed periods first
// R15: sampling resumes after every completed conversion
// R16: start bit stays set through both phases
// R17: eleven clock periods per twelve-bit conversion
// R18: seven clock sources by select field
// R19: software picks shortest legal conversion clock
// R20: acquisition field maps to listed period counts
// R21: format bit picks right or left justify
// R22: clearing start aborts, result pair kept
// R23: start ignored while converter disabled
// R24: unused result bits read zero
//
// The Avalon-MM register port and the placing of the registers were chosen for this implementation.
`include "sar_adc_defs.vh"
`default_nettype none

module sar_adc_sequencer #(
   parameter N_CHAN = 12
) (
   input wire ref_clk,
   input wire rstn,
   input wire [`ADDR_W-1:0] address,
   input wire read,
   input wire write,
   input wire [31:0] writedata,
   output reg [31:0] readdata,
   output reg waitrequest,
   input wire comp_in,
   input wire rc_osc_in,
   input wire sleep_mode,
   output reg [`RESULT_BITS-1:0] dac_code,
   output reg sample_en,
   output reg [3:0] channel_sel,
   output reg vref_pos_ext,
   output reg vref_neg_ext,
   output reg [N_CHAN-1:0] pin_analog,
   output reg conv_complete_flag
);

   // ****************************************
   // states and decode
   // ****************************************
   localparam [2:0] ST_IDLE = 3'h0;
   localparam [2:0] ST_HOLDOFF = 3'h1;
   localparam [2:0] ST_ACQ = 3'h2;
   localparam [2:0] ST_CONV = 3'h3;
   localparam [2:0] ST_GUARD = 3'h4;
   localparam integer HOLDOFF_CYC = `INSTR_CYCLE_CYC;

   function [4:0] acq_periods;
      input [2:0] sel;
      begin
         case (sel) // R20
            3'h5: acq_periods = 5'h0c;
            3'h6: acq_periods = 5'h10;
            3'h7: acq_periods = 5'h14;
            default: acq_periods = {1'b0, sel, 1'b0};
         endcase
      end
   endfunction

   // ****************************************
   // registers
   // ****************************************
   reg [7:0] control_zero_reg;
   reg [7:0] control_one_reg;
   reg [7:0] control_two_reg;
   reg [7:0] result_high_byte;
   reg [7:0] result_low_byte;
   reg [2:0] state_reg;
   reg [2:0] state_next;
   reg [6:0] div_cnt_reg;
   reg [4:0] tad_cnt_reg;
   reg [2:0] hold_cnt_reg;
   reg [`RESULT_BITS-1:0] sar_reg;
   reg [`RESULT_BITS-1:0] mask_reg;
   reg rc_meta_reg;
   reg rc_sync_reg;
   reg rc_prev_reg;

   wire enable = control_zero_reg[`BIT_ENABLE];
   wire busy = control_zero_reg[`BIT_START];
   wire [2:0] clk_sel = control_two_reg[`CLKSEL_LSB +: 3];
   wire [2:0] acq_sel = control_two_reg[`ACQ_LSB +: 3];
   wire use_rc = clk_sel[1] & clk_sel[0]; // R18
   wire [4:0] acq_len = acq_periods(acq_sel);

   // ****************************************
   // avalon slave handshake
   // ****************************************
   // one wait state: a write lands on the edge with waitrequest low, read data is latched on the edge before
   wire req = read | write;
   wire do_wr = write & ~waitrequest;
   wire [7:0] wbyte = writedata[7:0];
   wire wr_zero = do_wr && address == {1'b0, `OFS_CONTROL_ZERO};
   wire wr_one = do_wr && address == {1'b0, `OFS_CONTROL_ONE};
   wire wr_two = do_wr && address == {1'b0, `OFS_CONTROL_TWO};
   wire wr_high = do_wr && address == {1'b0, `OFS_RESULT_HIGH};
   wire wr_low = do_wr && address == `OFS_RESULT_LOW_FULL + 5'h04;
   wire wr_stat = do_wr && address == `OFS_STATUS;

   reg [7:0] rd_byte;
   always @* begin
      if (address == {1'b0, `OFS_CONTROL_ZERO}) begin
         rd_byte = control_zero_reg;
      end else if (address == {1'b0, `OFS_CONTROL_ONE}) begin
         rd_byte = control_one_reg;
      end else if (address == {1'b0, `OFS_CONTROL_TWO}) begin
         rd_byte = control_two_reg;
      end else if (address == {1'b0, `OFS_RESULT_HIGH}) begin
         rd_byte = result_high_byte;
      end else if (address == `OFS_STATUS) begin
         rd_byte = {7'h00, conv_complete_flag};
      end else if (address == `OFS_RESULT_LOW_FULL + 5'h04) begin
         rd_byte = result_low_byte;
      end else begin
         rd_byte = 8'h00;
      end
   end

   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         waitrequest <= 1'b1;
         readdata <= 32'h00000000;
      end else begin
         waitrequest <= ~(req & waitrequest);
         if (read & waitrequest) begin
            readdata <= {24'h000000, rd_byte};
         end
      end
   end

   // ****************************************
   // conversion clock
   // ****************************************
   // rc oscillator is foreign, so two flops before the edge detector
   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         {rc_prev_reg, rc_sync_reg, rc_meta_reg} <= 3'h0;
      end else begin
         {rc_prev_reg, rc_sync_reg, rc_meta_reg} <= {rc_sync_reg, rc_meta_reg, rc_osc_in};
      end
   end

   // period = 2 << (2*sel[1:0] + sel[2]) reference cycles
   wire [6:0] div_per = 7'h02 << {clk_sel[1:0], clk_sel[2]}; // R18
   wire clk_run = state_reg == ST_ACQ || state_reg == ST_CONV || state_reg == ST_GUARD;
   // the divided oscillator is stopped in sleep, only rc keeps going
   wire stall = sleep_mode & ~use_rc; // R3
   wire div_tick = div_cnt_reg == div_per - 7'h01;
   wire div_half = div_cnt_reg == {1'b0, div_per[6:1]} - 7'h01;
   wire tick = clk_run & (use_rc ? (rc_sync_reg & ~rc_prev_reg) : (~stall & div_tick));
   wire half = clk_run & (use_rc ? (~rc_sync_reg & rc_prev_reg) : (~stall & div_half));

   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         div_cnt_reg <= 7'h00;
      end else if (!clk_run || use_rc || div_tick) begin
         div_cnt_reg <= 7'h00;
      end else if (!stall) begin
         div_cnt_reg <= div_cnt_reg + 7'h01;
      end
   end

   // ****************************************
   // sequencer
   // ****************************************
   wire conv_done = state_reg == ST_CONV && tick && tad_cnt_reg == `CONV_PERIODS - 1; // R17
   // abort by clearing start or by turning the module off
   wire abort = (state_reg == ST_ACQ || state_reg == ST_CONV || state_reg == ST_HOLDOFF)
      && ((wr_zero && !wbyte[`BIT_START]) || !enable); // R22
   // next trial: load the msb, or keep or drop the trial bit and try the next one down
   wire sar_load = state_next == ST_CONV && state_reg != ST_CONV;
   wire sar_step = state_reg == ST_CONV && (tick || half) && mask_reg != 0;
   wire [`RESULT_BITS-1:0] msb_only = {1'b1, {(`RESULT_BITS-1){1'b0}}};
   wire [`RESULT_BITS-1:0] mask_next = sar_load ? msb_only : sar_step ? mask_reg >> 1 : mask_reg;
   wire [`RESULT_BITS-1:0] sar_next = sar_load ? msb_only : !sar_step ? sar_reg
      : (sar_reg & ~mask_reg) | (comp_in ? mask_reg : {`RESULT_BITS{1'b0}}) | (mask_reg >> 1);

   always @* begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: begin
            if (enable && busy) begin
               if (use_rc) begin
                  state_next = ST_HOLDOFF; // R1
               end else if (acq_len == 5'h00) begin
                  state_next = ST_CONV; // R13
               end else begin
                  state_next = ST_ACQ; // R14
               end
            end
         end
         ST_HOLDOFF: begin
            if (hold_cnt_reg == HOLDOFF_CYC - 1) begin
               state_next = (acq_len == 5'h00) ? ST_CONV : ST_ACQ; // R1
            end
         end
         ST_ACQ: begin
            if (tick && tad_cnt_reg == acq_len - 5'h01) begin
               state_next = ST_CONV; // R14
            end
         end
         ST_CONV: state_next = conv_done ? ST_GUARD : ST_CONV;
         ST_GUARD: state_next = (tick && tad_cnt_reg == `GUARD_PERIODS - 1) ? ST_IDLE // R10
            : ST_GUARD;
         default: state_next = ST_IDLE;
      endcase
      if (abort) begin
         state_next = ST_GUARD;
      end
   end

   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         state_reg <= ST_IDLE; // R7
         tad_cnt_reg <= 5'h00;
         hold_cnt_reg <= 3'h0;
         {sar_reg, mask_reg} <= {(2*`RESULT_BITS){1'b0}};
      end else begin
         state_reg <= state_next;
         hold_cnt_reg <= (state_reg == ST_HOLDOFF) ? hold_cnt_reg + 3'h1 : 3'h0;
         if (state_next != state_reg) begin
            tad_cnt_reg <= 5'h00;
         end else if (tick) begin
            tad_cnt_reg <= tad_cnt_reg + 5'h01;
         end
         sar_reg <= sar_next; // R4
         mask_reg <= mask_next;
      end
   end

   // ****************************************
   // control registers
   // ****************************************
   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         {control_zero_reg, control_one_reg, control_two_reg} <= {3{`RST_CONTROL}}; // R7
         conv_complete_flag <= 1'b0;
      end else begin
         if (wr_zero) begin
            control_zero_reg[7:2] <= wbyte[7:2];
            control_zero_reg[`BIT_ENABLE] <= wbyte[`BIT_ENABLE];
            // start only sticks when the module is already on
            control_zero_reg[`BIT_START] <= wbyte[`BIT_START] & enable; // R23
         end else if (conv_done || !enable) begin
            control_zero_reg[`BIT_START] <= 1'b0; // R6 R16
         end
         if (wr_one) begin
            control_one_reg <= wbyte; // R2 R5
         end
         if (wr_two) begin
            control_two_reg <= wbyte;
         end
         // completion wins over a clear in the same cycle
         if (conv_done) begin
            conv_complete_flag <= 1'b1; // R6
         end else if (wr_stat && wbyte[`BIT_FLAG]) begin
            conv_complete_flag <= 1'b0;
         end
      end
   end

   // ****************************************
   // result pair, never reset
   // ****************************************
   wire [`RESULT_BITS-1:0] final_code = sar_reg;
   always @(posedge ref_clk) begin
      if (conv_done) begin // R8
         if (control_two_reg[`FORMAT_BIT]) begin
            result_high_byte <= {4'h0, final_code[11:8]}; // R21 R24
            result_low_byte <= final_code[7:0];
         end else begin
            result_high_byte <= final_code[11:4]; // R21
            result_low_byte <= {final_code[3:0], 4'h0}; // R24
         end
      end else begin
         if (wr_high) begin
            result_high_byte <= wbyte; // R22
         end
         if (wr_low) begin
            result_low_byte <= wbyte;
         end
      end
   end

   // ****************************************
   // analog-side outputs
   // ****************************************
   wire [3:0] pcfg = control_one_reg[`PCFG_LSB +: 4];
   wire sample_next = enable && (state_next == ST_IDLE || state_next == ST_ACQ
      || (state_next == ST_HOLDOFF && acq_len != 5'h00)); // R12 R15 R11

   genvar i;
   generate
      for (i = 0; i < N_CHAN; i = i + 1) begin : g_pin
         always @(posedge ref_clk or negedge rstn) begin
            if (!rstn) begin
               pin_analog[i] <= 1'b1;
            end else begin
               pin_analog[i] <= (pcfg < 4'h4) || (i < 15 - pcfg); // R5
            end
         end
      end
   endgenerate

   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         {sample_en, vref_pos_ext, vref_neg_ext} <= 3'h0;
         dac_code <= {`RESULT_BITS{1'b0}};
         channel_sel <= 4'h0;
      end else begin
         sample_en <= sample_next; // R12
         // trial shown with the edge that makes it, so one-cycle decisions see it
         dac_code <= state_next == ST_CONV ? sar_next : {`RESULT_BITS{1'b0}}; // R4
         channel_sel <= control_zero_reg[`CHAN_LSB +: 4];
         vref_pos_ext <= control_one_reg[`VREF_POS_BIT]; // R2
         vref_neg_ext <= control_one_reg[`VREF_NEG_BIT]; // R2
      end
   end

endmodule // sar_adc_sequencer

`default_nettype wire
